/* File: fn_device.sv */
// Slave end: function-command interpreter, memory, pins and reply FIFO
`timescale 1ns/100ps
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             srst_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              wr = in_valid_in & in_ready_out;
  wire              rd = out_valid_out & out_ready_in;
  wire [AW:0]       cnt_d = cnt_q + (AW+1)'(wr) - (AW+1)'(rd);

  assign out_data_out = mem_q[rp_q];

  always_ff @(posedge clk_sys_in) begin
    if (wr) begin
      mem_q[wp_q] <= in_data_in;
    end
  end

  // Flags registered so both handshake outputs come from flops
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || flush_in) begin
      wp_q          <= '0;
      rp_q          <= '0;
      cnt_q         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      wp_q          <= wp_q + AW'(wr);
      rp_q          <= rp_q + AW'(rd);
      cnt_q         <= cnt_d;
      in_ready_out  <= cnt_d != (AW+1)'(DEPTH);
      out_valid_out <= cnt_d != '0;
    end
  end
endmodule : byte_fifo

module fn_device #(
  parameter int unsigned PROG_CYC = fn_pkg::prog_cyc
) (
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  fn_link_if.dev          link,
  input  wire logic [1:0] pio_pin_in,
  output logic      [1:0] pio_oe_out,
  output logic      [1:0] pio_o_out,
  output logic      [1:0] activity_out
);
  typedef enum {ST_CMD, ST_TA1, ST_TA2, ST_ES, ST_WS, ST_RS_HDR, ST_RS_DATA, ST_CRC, ST_PROG, ST_RM,
                ST_REG_WRITE_CMD, ST_PR, ST_PW_A, ST_PW_B, ST_PULSE, ST_SETTLE, ST_PW_AA, ST_PW_ST,
                ST_FF, ST_AA, ST_DEAD} state_e;

  state_e      state_q;
  logic [7:0]  eeprom_q [512];
  logic [7:0]  scratch_q [32];
  logic [7:0]  prot_q [16];
  logic [7:0]  ctl_q [3];
  logic [7:0]  cmd_q;
  logic [7:0]  a_q;
  logic [15:0] adr_q;
  logic [15:0] ta_q;
  logic [4:0]  off_q;
  logic        aa_q;
  logic        pf_q;
  logic        got_q;
  logic        copied_q;
  logic        is_pulse_q;
  logic        ret_pr_q;
  logic        rx_rdy_q;
  logic [9:0]  cnt_q;
  logic [15:0] crc_q;
  logic [31:0] prog_cnt_q;
  logic [15:0] pul_cnt_q;
  logic [1:0]  latch_q;
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic [1:0]  prev_q;
  logic [7:0]  tx_byte;
  logic        fifo_ready;

  wire         take     = link.m2s_valid & rx_rdy_q;
  wire [7:0]   rxb      = link.m2s_byte;
  wire [15:0]  full_adr = {rxb, adr_q[7:0]};
  wire [7:0]   es_byte  = {aa_q, 1'b0, pf_q, off_q};
  wire [7:0]   status   = {fn_pkg::pin_pad, pin_s2_q};
  wire         is_rx    = state_q inside {ST_CMD, ST_TA1, ST_TA2, ST_ES, ST_WS, ST_REG_WRITE_CMD, ST_PW_A, ST_PW_B};
  wire         is_tx    = state_q inside {ST_RS_HDR, ST_RS_DATA, ST_CRC, ST_RM, ST_PR, ST_PW_AA, ST_PW_ST,
                                          ST_FF, ST_AA};
  wire         push     = is_tx & fifo_ready;
  wire         crc_on   = state_q inside {ST_RS_HDR, ST_RS_DATA, ST_PR};
  wire [15:0]  cur_adr  = {6'h00, cnt_q};
  wire         act_clr  = state_q == ST_CMD && take && rxb == fn_pkg::activity_clear_cmd;
  wire         sp_we    = state_q == ST_WS && take;
  wire         ee_we    = state_q == ST_PROG && !copied_q;
  wire         ctl_we   = state_q == ST_REG_WRITE_CMD && take;
  wire         pulsing  = state_q == ST_PULSE;
  wire [1:0]   level    = latch_q ^ (pulsing ? a_q[1:0] : 2'h0);
  wire         auth_ok  = adr_q == ta_q && rxb == es_byte && ta_q < fn_pkg::reg_base && !pf_q
                          && prot_q[ta_q[8:5]] != fn_pkg::prot_code;
  wire         pin_ok   = rxb == ~a_q;

  // Memory map read: array pages, protect bytes, pin registers, control
  function automatic logic [7:0] map_rd(input logic [15:0] a);
    if (a < fn_pkg::reg_base) return eeprom_q[a[8:0]];
    if (a <= fn_pkg::prot_last) return prot_q[a[3:0]];
    if (a == fn_pkg::pin_status_addr) return status;
    if (a == fn_pkg::latch_addr) return {fn_pkg::pin_pad, latch_q};
    if (a == fn_pkg::act_addr) return {6'h00, activity_out};
    if (a >= fn_pkg::reg_write_cmd_first && a <= fn_pkg::mem_last) return ctl_q[a[1:0] - 2'h3];
    return fn_pkg::fill_byte;
  endfunction : map_rd

  always_comb begin
    case (state_q)
      ST_RS_HDR:  tx_byte = cnt_q[1:0] == 2'h0 ? ta_q[7:0] : cnt_q[1:0] == 2'h1 ? ta_q[15:8] : es_byte;
      ST_RS_DATA: tx_byte = scratch_q[cnt_q[4:0]];
      ST_CRC:     tx_byte = cnt_q[0] ? ~crc_q[15:8] : ~crc_q[7:0];
      ST_RM:      tx_byte = map_rd(cur_adr);
      ST_PR:      tx_byte = status;
      ST_PW_ST:   tx_byte = status;
      ST_PW_AA:   tx_byte = fn_pkg::ok_byte;
      ST_AA:      tx_byte = fn_pkg::ok_byte;
      default:    tx_byte = fn_pkg::fill_byte;
    endcase
  end

  byte_fifo #(.WIDTH(8), .DEPTH(8)) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .srst_in       (srst_in),
    .flush_in      (link.link_rst),
    .in_valid_in   (push),
    .in_data_in    (tx_byte),
    .in_ready_out  (fifo_ready),
    .out_valid_out (link.s2m_valid),
    .out_data_out  (link.s2m_byte),
    .out_ready_in  (link.s2m_ready)
  );

  always_ff @(posedge clk_sys_in) begin
    if (sp_we) begin
      scratch_q[cnt_q[4:0]] <= rxb;
    end
    if (ee_we) begin
      eeprom_q[{ta_q[8:5], cnt_q[4:0]}] <= scratch_q[cnt_q[4:0]];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctl_q <= '{default: 8'h00};
      prot_q <= '{default: 8'h00};
    end else if (ctl_we) begin
      ctl_q[cnt_q[1:0] - 2'h3] <= rxb;
    end
  end

  // Pin synchroniser, output drive and sticky activity; set wins over clear
  always_ff @(posedge clk_sys_in) begin
    pin_s1_q <= pio_pin_in;
    pin_s2_q <= pin_s1_q;
    if (srst_in) begin
      prev_q       <= 2'h3;
      pio_oe_out   <= 2'h0;
      pio_o_out    <= 2'h0;
      link.prog_busy <= 1'b0;
    end else begin
      prev_q       <= pin_s2_q;
      pio_oe_out   <= ~level;
      pio_o_out    <= 2'h0;
      link.prog_busy <= state_q == ST_PROG;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_act
    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        activity_out[i] <= 1'b0;
      end else begin
        activity_out[i] <= (pin_s2_q[i] != prev_q[i]) | (activity_out[i] & ~act_clr);
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ta_q <= '0;
      off_q <= '0;
      aa_q <= 1'b0;
      pf_q <= 1'b0;
      got_q <= 1'b0;
      latch_q <= 2'h3;
    end else if (state_q == ST_TA2 && take && cmd_q == fn_pkg::scratch_write_cmd) begin
      ta_q <= full_adr;
      off_q <= full_adr[4:0];
      aa_q <= 1'b0;
      pf_q <= 1'b0;
      got_q <= 1'b0;
    end else if (sp_we) begin
      off_q <= cnt_q[4:0];
      got_q <= 1'b1;
    end else if (link.link_rst && state_q == ST_WS && !got_q) begin
      pf_q <= 1'b1;
    end else if (state_q == ST_PROG && prog_cnt_q == 32'(PROG_CYC - 1)) begin
      aa_q <= 1'b1;
    end else if (state_q == ST_PW_B && take && pin_ok && !is_pulse_q) begin
      latch_q <= a_q[1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || link.link_rst) begin
      state_q <= ST_CMD;
      cmd_q <= '0;
      a_q <= '0;
      adr_q <= '0;
      cnt_q <= '0;
      crc_q <= '0;
      prog_cnt_q <= '0;
      pul_cnt_q <= '0;
      copied_q <= 1'b0;
      is_pulse_q <= 1'b0;
      ret_pr_q <= 1'b0;
      rx_rdy_q <= 1'b0;
    end else begin
      rx_rdy_q <= is_rx && !take;
      if (take) begin
        crc_q <= fn_pkg::crc16_byte(state_q == ST_CMD ? 16'h0000 : crc_q, rxb);
      end else if (push && crc_on) begin
        crc_q <= fn_pkg::crc16_byte(crc_q, tx_byte);
      end
      case (state_q)
        ST_CMD: if (take) begin
          cmd_q <= rxb;
          cnt_q <= '0;
          is_pulse_q <= rxb == fn_pkg::pin_pulse_cmd;
          ret_pr_q <= rxb == fn_pkg::pin_read_cmd;
          case (rxb)
            fn_pkg::scratch_write_cmd, fn_pkg::scratch_copy_cmd,
            fn_pkg::mem_read_cmd, fn_pkg::reg_write_cmd: state_q <= ST_TA1;
            fn_pkg::scratch_read_cmd:   state_q <= ST_RS_HDR;
            fn_pkg::pin_read_cmd:       state_q <= ST_PR;
            fn_pkg::pin_write_cmd, fn_pkg::pin_pulse_cmd: state_q <= ST_PW_A;
            fn_pkg::activity_clear_cmd: state_q <= ST_AA;
            default:                    state_q <= ST_DEAD;
          endcase
        end
        ST_TA1: if (take) begin
          adr_q[7:0] <= rxb;
          state_q <= ST_TA2;
        end
        ST_TA2: if (take) begin
          adr_q[15:8] <= rxb;
          cnt_q <= full_adr[9:0];
          case (cmd_q)
            fn_pkg::scratch_write_cmd: state_q <= ST_WS;
            fn_pkg::scratch_copy_cmd:  state_q <= ST_ES;
            fn_pkg::mem_read_cmd:      state_q <= full_adr <= fn_pkg::mem_last ? ST_RM : ST_FF;
            default: state_q <= (full_adr >= fn_pkg::reg_write_cmd_first && full_adr <= fn_pkg::mem_last)
                                ? ST_REG_WRITE_CMD : ST_FF;
          endcase
        end
        ST_WS: if (take) begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q[4:0] == fn_pkg::sp_last) begin
            cnt_q <= '0;
            state_q <= ST_CRC;
          end
        end
        ST_RS_HDR: if (push) begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q[1:0] == fn_pkg::hdr_last) begin
            cnt_q <= {5'h00, ta_q[4:0]};
            state_q <= ST_RS_DATA;
          end
        end
        ST_RS_DATA: if (push) begin
          cnt_q <= {5'h00, cnt_q[4:0] + 5'h01};
          if (cnt_q[4:0] == off_q) begin
            cnt_q <= '0;
            state_q <= ST_CRC;
          end
        end
        ST_CRC: if (push) begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q[0]) begin
            cnt_q <= '0;
            crc_q <= '0;
            state_q <= ret_pr_q ? ST_PR : ST_FF;
          end
        end
        ST_ES: if (take) begin
          cnt_q <= {5'h00, ta_q[4:0]};
          state_q <= auth_ok ? ST_PROG : ST_FF;
        end
        ST_PROG: begin
          prog_cnt_q <= prog_cnt_q + 32'h1;
          if (!copied_q) begin
            cnt_q <= {5'h00, cnt_q[4:0] + 5'h01};
            copied_q <= cnt_q[4:0] == off_q;
          end
          if (prog_cnt_q == 32'(PROG_CYC - 1)) begin
            state_q <= ST_AA;
          end
        end
        ST_RM: if (push) begin
          cnt_q <= cnt_q + 10'h001;
          if (cur_adr == fn_pkg::mem_last) begin
            state_q <= ST_FF;
          end
        end
        ST_REG_WRITE_CMD: if (take) begin
          cnt_q <= cnt_q + 10'h001;
          if (cur_adr == fn_pkg::mem_last) begin
            state_q <= ST_FF;
          end
        end
        ST_PR: if (push) begin
          cnt_q <= cnt_q + 10'h001;
          if (cnt_q[4:0] == fn_pkg::pin_group_last) begin
            cnt_q <= '0;
            state_q <= ST_CRC;
          end
        end
        ST_PW_A: if (take) begin
          a_q <= rxb;
          state_q <= ST_PW_B;
        end
        ST_PW_B: if (take) begin
          pul_cnt_q <= is_pulse_q ? fn_pkg::pulse_cyc : fn_pkg::settle_cyc;
          state_q <= !pin_ok ? ST_FF : is_pulse_q ? ST_PULSE : ST_SETTLE;
        end
        ST_PULSE: begin
          pul_cnt_q <= pul_cnt_q - 16'h0001;
          if (pul_cnt_q == 16'h0001) begin
            pul_cnt_q <= fn_pkg::settle_cyc;
            state_q <= ST_SETTLE;
          end
        end
        // Let the new level pass the pin synchroniser before status is sampled
        ST_SETTLE: begin
          pul_cnt_q <= pul_cnt_q - 16'h0001;
          if (pul_cnt_q == 16'h0001) begin
            state_q <= ST_PW_AA;
          end
        end
        ST_PW_AA: if (push) begin
          state_q <= ST_PW_ST;
        end
        ST_PW_ST: if (push) begin
          state_q <= is_pulse_q ? ST_FF : ST_PW_A;
        end
        ST_FF, ST_AA, ST_DEAD: state_q <= state_q;
        default: state_q <= ST_CMD;
      endcase
    end
  end

  assign link.m2s_ready = rx_rdy_q;
endmodule : fn_device

/* File: fn_pkg.sv */
// Shared constants, codes and helpers for the function-command link
package fn_pkg;
  localparam logic [7:0]  scratch_write_cmd  = 8'h0f;
  localparam logic [7:0]  scratch_read_cmd   = 8'haa;
  localparam logic [7:0]  scratch_copy_cmd   = 8'h55;
  localparam logic [7:0]  mem_read_cmd       = 8'hf0;
  localparam logic [7:0]  reg_write_cmd      = 8'h99;
  localparam logic [7:0]  pin_read_cmd       = 8'hf5;
  localparam logic [7:0]  pin_write_cmd      = 8'h5a;
  localparam logic [7:0]  pin_pulse_cmd      = 8'ha5;
  localparam logic [7:0]  activity_clear_cmd = 8'hc3;
  localparam logic [7:0]  ok_byte            = 8'haa;
  localparam logic [7:0]  fill_byte          = 8'hff;
  localparam logic [7:0]  prot_code          = 8'h55;
  localparam logic [15:0] reg_base           = 16'h0200;
  localparam logic [15:0] prot_last          = 16'h020f;
  localparam logic [15:0] pin_status_addr    = 16'h0220;
  localparam logic [15:0] latch_addr         = 16'h0221;
  localparam logic [15:0] act_addr           = 16'h0222;
  localparam logic [15:0] reg_write_cmd_first         = 16'h0223;
  localparam logic [15:0] mem_last           = 16'h0225;
  localparam logic [4:0]  sp_last            = 5'h1f;
  localparam logic [4:0]  pin_group_last     = 5'h1f;
  localparam logic [1:0]  hdr_last           = 2'h2;
  localparam logic [5:0]  pin_pad            = 6'h3f;
  localparam logic [2:0]  copy_auth_bytes    = 3'h4;
  localparam logic [15:0] crc_poly_rev       = 16'ha001;
  localparam int unsigned clk_mhz            = 100;
  localparam int unsigned prog_time_us       = 10000;
  localparam int unsigned prog_cyc           = prog_time_us * clk_mhz;
  localparam int unsigned pulse_time_us      = 1;
  localparam logic [15:0] pulse_cyc          = 16'(pulse_time_us * clk_mhz);
  localparam logic [15:0] settle_cyc         = 16'h0004;

  // CRC16, reflected polynomial, one byte LSB first
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ crc_poly_rev) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte
endpackage : fn_pkg

/* File: fn_link_if.sv */
// Byte-level link between the bus master and the function-command slave
`timescale 1ns/100ps
interface fn_link_if;
  logic       link_rst;
  logic       m2s_valid;
  logic [7:0] m2s_byte;
  logic       m2s_ready;
  logic       s2m_valid;
  logic [7:0] s2m_byte;
  logic       s2m_ready;
  logic       prog_busy;

  modport dev  (input link_rst, m2s_valid, m2s_byte, s2m_ready,
                output m2s_ready, s2m_valid, s2m_byte, prog_busy);
  modport host (output link_rst, m2s_valid, m2s_byte, s2m_ready,
                input m2s_ready, s2m_valid, s2m_byte, prog_busy);
endinterface : fn_link_if

/* File: fn_host.sv */
// Master end: frames user bytes onto the link and keeps programming quiet
`timescale 1ns/100ps
module fn_host #(
  parameter int unsigned PROG_CYC = fn_pkg::prog_cyc
) (
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  fn_link_if.host         link,
  input  wire logic       user_frame_in,
  input  wire logic       user_tx_valid_in,
  input  wire logic [7:0] user_tx_byte_in,
  output logic            user_tx_ack_out,
  input  wire logic       user_rx_req_in,
  output logic            user_rx_valid_out,
  output logic      [7:0] user_rx_byte_out,
  output logic            user_busy_out
);
  logic [31:0] quiet_q;
  logic [2:0]  nbytes_q;
  logic [7:0]  first_q;
  logic        m2s_valid_q;
  logic [7:0]  m2s_byte_q;
  logic        s2m_ready_q;
  logic        link_rst_q;

  wire quiet   = quiet_q != '0 || link.prog_busy;
  wire sent    = m2s_valid_q & link.m2s_ready;
  wire got     = link.s2m_valid & s2m_ready_q;
  wire load    = user_tx_valid_in && !m2s_valid_q && !user_tx_ack_out && !quiet;
  wire auth_end = sent && first_q == fn_pkg::scratch_copy_cmd && nbytes_q == fn_pkg::copy_auth_bytes - 3'h1;

  assign link.m2s_valid = m2s_valid_q;
  assign link.m2s_byte  = m2s_byte_q;
  assign link.s2m_ready = s2m_ready_q;
  assign link.link_rst  = link_rst_q;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      quiet_q <= '0;
    end else if (auth_end) begin
      quiet_q <= 32'(PROG_CYC);
    end else if (quiet_q != '0) begin
      quiet_q <= quiet_q - 32'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      link_rst_q        <= 1'b0;
      nbytes_q          <= '0;
      first_q           <= '0;
      m2s_valid_q       <= 1'b0;
      m2s_byte_q        <= '0;
      s2m_ready_q       <= 1'b0;
      user_tx_ack_out   <= 1'b0;
      user_rx_valid_out <= 1'b0;
      user_rx_byte_out  <= '0;
      user_busy_out     <= 1'b0;
    end else begin
      link_rst_q        <= user_frame_in && !quiet;
      user_tx_ack_out   <= load;
      user_rx_valid_out <= got;
      user_busy_out     <= quiet;
      if (got) begin
        user_rx_byte_out <= link.s2m_byte;
      end
      if (link_rst_q) begin
        nbytes_q    <= '0;
        m2s_valid_q <= 1'b0;
        s2m_ready_q <= 1'b0;
      end else begin
        if (load) begin
          m2s_valid_q <= 1'b1;
          m2s_byte_q  <= user_tx_byte_in;
        end else if (sent) begin
          m2s_valid_q <= 1'b0;
          if (nbytes_q == '0) begin
            first_q <= m2s_byte_q;
          end
          if (nbytes_q != 3'h7) begin
            nbytes_q <= nbytes_q + 3'h1;
          end
        end
        if (got) begin
          s2m_ready_q <= 1'b0;
        end else if (user_rx_req_in && !quiet) begin
          s2m_ready_q <= 1'b1;
        end
      end
    end
  end
endmodule : fn_host

/* File: fn_link_sva.sv */
// Protocol checks on the byte link between the host and device ends
`timescale 1ns/100ps
module fn_link_sva #(
  parameter int unsigned PROG_CYC = fn_pkg::prog_cyc
) (
  input wire logic       clk_sys_in,
  input wire logic       srst_in,
  input wire logic       link_rst,
  input wire logic       m2s_valid,
  input wire logic [7:0] m2s_byte,
  input wire logic       m2s_ready,
  input wire logic       s2m_valid,
  input wire logic [7:0] s2m_byte,
  input wire logic       s2m_ready,
  input wire logic       prog_busy
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  logic [31:0] busy_cnt_q;
  logic        after_prog_q;

  // Length of the current programming window
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !prog_busy)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end

  // Frame tail after a finished copy, cleared by a new frame
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || link_rst)
      after_prog_q <= 1'b0;
    else if ($fell(prog_busy))
      after_prog_q <= 1'b1;
  end

  property p_m2s_hold;
    m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_byte);
  endproperty
  a_m2s_hold: assert property (p_m2s_hold) else $error("m2s byte changed before take");
  property p_m2s_drop;
    m2s_valid && m2s_ready |=> !m2s_valid;
  endproperty
  a_m2s_drop: assert property (p_m2s_drop) else $error("m2s valid held after take");
  property p_ready_gap;
    m2s_valid && m2s_ready |=> !m2s_ready;
  endproperty
  a_ready_gap: assert property (p_ready_gap) else $error("m2s ready stayed high after take");
  property p_s2m_hold;
    s2m_valid && !s2m_ready && !link_rst |=> s2m_valid && $stable(s2m_byte);
  endproperty
  a_s2m_hold: assert property (p_s2m_hold) else $error("s2m byte lost before read");
  property p_quiet;
    prog_busy |-> !m2s_valid && !m2s_ready && !s2m_ready;
  endproperty
  a_quiet: assert property (p_quiet) else $error("link activity while programming");
  property p_copy_ok;
    after_prog_q && s2m_valid |-> s2m_byte == fn_pkg::ok_byte;
  endproperty
  a_copy_ok: assert property (p_copy_ok) else $error("copy status byte not ok");
  property p_prog_len;
    $fell(prog_busy) |-> busy_cnt_q >= PROG_CYC && busy_cnt_q <= PROG_CYC + 1;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("programming window wrong length");
  property p_flush;
    link_rst |=> ##1 !s2m_valid;
  endproperty
  a_flush: assert property (p_flush) else $error("reply queue not flushed by frame start");
endmodule : fn_link_sva

/* File: testbench.sv */
// Self-checking bench joining host and device ends through the link
`timescale 1ns/100ps
module testbench;
  localparam int unsigned PROG_CYC = 50;
  logic       clk_sys_in, srst_in, user_frame_in, user_tx_valid_in, user_rx_req_in;
  logic [7:0] user_tx_byte_in, user_rx_byte_out;
  logic       user_tx_ack_out, user_rx_valid_out, user_busy_out;
  logic [1:0] pio_oe_out, pio_o_out, activity_out;
  wire  [1:0] pio_pin_in;
  logic [15:0] acc;
  int         n_fail, cmp_count, cyc;

  fn_link_if link_i ();
  fn_device #(.PROG_CYC(PROG_CYC)) u_fn_device (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .link(link_i),
    .pio_pin_in(pio_pin_in), .pio_oe_out(pio_oe_out), .pio_o_out(pio_o_out), .activity_out(activity_out));
  fn_host #(.PROG_CYC(PROG_CYC)) u_fn_host (.clk_sys_in(clk_sys_in), .srst_in(srst_in), .link(link_i),
    .user_frame_in(user_frame_in), .user_tx_valid_in(user_tx_valid_in), .user_tx_byte_in(user_tx_byte_in),
    .user_tx_ack_out(user_tx_ack_out), .user_rx_req_in(user_rx_req_in), .user_rx_valid_out(user_rx_valid_out),
    .user_rx_byte_out(user_rx_byte_out), .user_busy_out(user_busy_out));
  fn_link_sva #(.PROG_CYC(PROG_CYC)) u_fn_link_sva (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .link_rst(link_i.link_rst), .m2s_valid(link_i.m2s_valid), .m2s_byte(link_i.m2s_byte),
    .m2s_ready(link_i.m2s_ready), .s2m_valid(link_i.s2m_valid), .s2m_byte(link_i.s2m_byte),
    .s2m_ready(link_i.s2m_ready), .prog_busy(link_i.prog_busy));

  // Pull-ups on both pins; an enabled pin is pulled low
  assign pio_pin_in = ~pio_oe_out;

  always #5 clk_sys_in = ~clk_sys_in;

  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [15:0] crc(input logic [15:0] c_in, input logic [7:0] b);
    logic [15:0] c;
    c = c_in ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction : crc

  // Optionally opens a frame, then hands each byte over and waits for its ack
  task automatic send(input bit start, input logic [7:0] b[$]);
    int n;
    if (start) begin
      user_frame_in = 1'b1;
      step();
      user_frame_in = 1'b0;
      step();
    end
    foreach (b[i]) begin
      n = 0;
      user_tx_byte_in = b[i];
      user_tx_valid_in = 1'b1;
      step();
      while (user_tx_ack_out !== 1'b1 && n < 2000) begin
        step();
        n++;
      end
      chk("byte ack", {15'h0000, user_tx_ack_out}, 16'h0001);
      user_tx_valid_in = 1'b0;
      step();
    end
  endtask : send

  // Reads one reply byte, folding the expected value into the running CRC
  task automatic rx(input logic [7:0] e, input bit do_chk);
    int n;
    n = 0;
    while (user_busy_out !== 1'b0 && n < 2000) begin
      step();
      n++;
    end
    user_rx_req_in = 1'b1;
    step();
    // Busy lags a cycle; keep asking until the host arms its ready
    while (link_i.s2m_ready !== 1'b1 && n < 4000) begin
      step();
      n++;
    end
    user_rx_req_in = 1'b0;
    while (user_rx_valid_out !== 1'b1 && n < 4000) begin
      step();
      n++;
    end
    chk("reply valid", {15'h0000, user_rx_valid_out}, 16'h0001);
    if (do_chk) chk("reply byte", {8'h00, user_rx_byte_out}, {8'h00, e});
    acc = crc(acc, e);
  endtask : rx

  task automatic t_scratch();
    logic [15:0] c;
    send(1, '{fn_pkg::scratch_write_cmd, 8'h21, 8'h00, 8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4});
    send(1, '{fn_pkg::scratch_read_cmd});
    acc = crc(16'h0000, 8'haa);
    rx(8'h21, 1);
    rx(8'h00, 1);
    rx(8'h05, 1);
    for (int i = 0; i < 5; i++) rx(8'hc0 + 8'(i), 1);
    c = ~acc;
    rx(c[7:0], 1);
    rx(c[15:8], 1);
    rx(8'hff, 1);
  endtask : t_scratch

  task automatic t_copy();
    send(1, '{fn_pkg::scratch_copy_cmd, 8'h21, 8'h00, 8'h05});
    step();
    chk("host busy", {15'h0000, user_busy_out}, 16'h0001);
    chk("prog busy", {15'h0000, link_i.prog_busy}, 16'h0001);
    rx(8'haa, 1);
    rx(8'haa, 1);
    send(1, '{fn_pkg::mem_read_cmd, 8'h21, 8'h00});
    for (int i = 0; i < 5; i++) rx(8'hc0 + 8'(i), 1);
    send(1, '{fn_pkg::mem_read_cmd, 8'h26, 8'h02});
    rx(8'hff, 1);
    send(1, '{fn_pkg::scratch_copy_cmd, 8'h21, 8'h00, 8'h06});
    rx(8'hff, 1);
  endtask : t_copy

  task automatic t_pins();
    logic [15:0] c;
    send(1, '{fn_pkg::pin_write_cmd, 8'hfc, 8'h03});
    rx(8'haa, 1);
    rx(8'hfc, 1);
    chk("pin enables", {14'h0, pio_oe_out}, 16'h0003);
    chk("pin drive level", {14'h0, pio_o_out}, 16'h0000);
    send(0, '{8'hff, 8'h00});
    rx(8'haa, 1);
    rx(8'hff, 1);
    send(1, '{fn_pkg::pin_write_cmd, 8'hfc, 8'hfc});
    rx(8'hff, 1);
    chk("pin enables", {14'h0, pio_oe_out}, 16'h0000);
    send(1, '{fn_pkg::pin_read_cmd});
    acc = crc(16'h0000, fn_pkg::pin_read_cmd);
    for (int i = 0; i < 32; i++) rx(8'hff, 1);
    c = ~acc;
    rx(c[7:0], 1);
    rx(c[15:8], 1);
    rx(8'hff, 1);
  endtask : t_pins

  task automatic t_pulse();
    send(1, '{fn_pkg::pin_pulse_cmd, 8'hfe, 8'h01});
    rx(8'haa, 1);
    rx(8'hff, 1);
    rx(8'hff, 1);
    send(1, '{fn_pkg::pin_pulse_cmd, 8'hfe, 8'hfe});
    rx(8'hff, 1);
    chk("activity", {14'h0, activity_out}, 16'h0003);
    send(1, '{fn_pkg::activity_clear_cmd});
    rx(8'haa, 1);
    chk("activity", {14'h0, activity_out}, 16'h0000);
    rx(8'haa, 1);
  endtask : t_pulse

  task automatic t_regs();
    send(1, '{fn_pkg::reg_write_cmd, 8'h23, 8'h02, 8'h11, 8'h22, 8'h33});
    rx(8'hff, 1);
    send(1, '{fn_pkg::mem_read_cmd, 8'h20, 8'h02});
    rx(8'hff, 1);
    rx(8'hff, 1);
    rx(8'h00, 1);
    rx(8'h11, 1);
    rx(8'h22, 1);
    rx(8'h33, 1);
    rx(8'hff, 1);
  endtask : t_regs

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the several hundred cycles the run needs
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    clk_sys_in = 1'b0;
    srst_in = 1'b1;
    user_frame_in = 1'b0;
    user_tx_valid_in = 1'b0;
    user_tx_byte_in = 8'h00;
    user_rx_req_in = 1'b0;
    acc = 16'h0000;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (5) @(posedge clk_sys_in);
    #1;
    srst_in = 1'b0;
    t_scratch();
    t_copy();
    t_pins();
    t_pulse();
    t_regs();
    tally_and_finish();
  end
endmodule : testbench
